/* sscrc_pkg.sv */
// Package: register map, field positions and reset values for the SPI status and CRC block
package sscrc_pkg;
  localparam int SSCRC_ADDR_W = 16;
  // Printed offsets are not all multiples of four, so each is kept as a register index
  localparam logic [15:0] SSCRC_IDX_CONTROL = 16'hC0CA;
  localparam logic [15:0] SSCRC_IDX_IRQ_ENABLE = 16'hC0CC;
  localparam logic [15:0] SSCRC_IDX_STATUS = 16'hC0CE;
  localparam logic [15:0] SSCRC_IDX_IRQ_CLEAR = 16'hC0D0;
  localparam logic [15:0] SSCRC_IDX_CRC_CONTROL = 16'hC0D2;
  localparam logic [15:0] SSCRC_IDX_CRC_VALUE = 16'hC0D4;
  localparam logic [15:0] SSCRC_IDX_DATA_PORT = 16'hC0D6;
  localparam logic [15:0] SSCRC_IDX_CONFIG = 16'hC0C8;
  // Status bits
  localparam int SSCRC_ST_FIFO_ERR = 7;
  localparam int SSCRC_ST_RX_IRQ = 2;
  localparam int SSCRC_ST_TX_IRQ = 1;
  localparam int SSCRC_ST_XFER_IRQ = 0;
  // Control register bits
  localparam int SSCRC_CT_FIFO_INIT = 14;
  localparam int SSCRC_CT_FULL_DUPLEX = 12;
  localparam int SSCRC_CT_TX_EMPTY = 7;
  localparam int SSCRC_CT_RX_FULL = 6;
  // Configuration register: three-wire enable
  localparam int SSCRC_CFG_THREE_WIRE = 0;
  // Interrupt clear bits
  localparam int SSCRC_CLR_TX = 1;
  localparam int SSCRC_CLR_XFER = 0;
  // CRC control fields
  localparam int SSCRC_CC_MODE_HI = 15;
  localparam int SSCRC_CC_MODE_LO = 14;
  localparam int SSCRC_CC_ENABLE = 13;
  localparam int SSCRC_CC_PRESET = 12;
  localparam int SSCRC_CC_RX_SEL = 11;
  localparam int SSCRC_CC_NOT_ZERO = 10;
  localparam int SSCRC_CC_NOT_ONES = 9;
  localparam logic [15:0] SSCRC_CC_WR_MASK = 16'hE800;
  localparam logic [15:0] SSCRC_CRC_RESET = 16'hFFFF;
  localparam logic [15:0] SSCRC_CRC7_MASK = 16'h007F;
  localparam logic [2:0] SSCRC_IEN_MASK = 3'h7;
  // Polynomial taps, top term implied
  localparam logic [15:0] SSCRC_POLY_CCITT = 16'h1021;
  localparam logic [15:0] SSCRC_POLY_ALT16 = 16'h8005;
  localparam logic [15:0] SSCRC_POLY_CRC7 = 16'h0009;
  typedef enum logic [1:0] {
    SSCRC_MODE_CCITT = 2'b00,
    SSCRC_MODE_CRC7 = 2'b01,
    SSCRC_MODE_ALT16 = 2'b10,
    SSCRC_MODE_RSVD = 2'b11
  } sscrc_mode_type;
endpackage

/* sscrc_crc_engine.sv */
// Bit-serial CRC step for the selectable polynomials
module sscrc_crc_engine
  import sscrc_pkg::*;
(
  input wire logic [1:0] mode_in,
  input wire logic [15:0] crc_in,
  input wire logic bit_in,
  output logic [15:0] crc_out
);
  logic feedback;
  always_comb begin
    feedback = 1'b0;
    crc_out = crc_in;
    case (sscrc_mode_type'(mode_in))
      SSCRC_MODE_CRC7: begin
        // Seven-bit register lives in bits 6:0; upper bits are left untouched
        feedback = crc_in[6] ^ bit_in;
        crc_out = {crc_in[15:7], (({crc_in[5:0], 1'b0}) ^ (feedback ? SSCRC_POLY_CRC7[6:0] : 7'h00))};
      end
      SSCRC_MODE_ALT16: begin
        feedback = crc_in[15] ^ bit_in;
        crc_out = {crc_in[14:0], 1'b0} ^ (feedback ? SSCRC_POLY_ALT16 : 16'h0000);
      end
      default: begin
        // Reserved code falls back to the first polynomial
        feedback = crc_in[15] ^ bit_in;
        crc_out = {crc_in[14:0], 1'b0} ^ (feedback ? SSCRC_POLY_CCITT : 16'h0000);
      end
    endcase
  end
endmodule // sscrc_crc_engine

/* sscrc_top.sv */
// SPI status, interrupt clear and CRC register block with Avalon-MM slave
// Functional notes
// - Status bit 7 flags FIFO error; with transmit empty means transmit underflow.
// - FIFO error with receive full means receive overflow.
// - FIFO error clears when software sets FIFO init.
// - Status bit 2 shows byte-mode receive interrupt; read only.
// - Status bit 1 shows byte-mode transmit interrupt; read only.
// - Status bit 0 shows block-mode transfer interrupt; read only.
// - Status register is read only; writes change nothing.
// - Writing 1 to clear bit 1 clears transmit interrupt; self-clearing.
// - Writing 1 to clear bit 0 clears transfer interrupt; self-clearing.
// - Polynomial code 00 selects x^16+x^12+x^5+1.
// - Polynomial code 01 selects seven-bit x^7+x^3+1.
// - Code 10 selects x^16+x^15+x^2+1; code 11 reserved.
// - CRC control bit 13 enables CRC computation.
// - Writing 1 to bit 12 presets CRC to all ones; reads zero.
// - Bit 11 picks receive or transmit stream in full duplex only.
// - Bit 10 reads 1 when CRC value is not all zeros.
// - Bit 9 reads 1 when CRC value is not all ones.
// - Sixteen-bit CRC value register, read/write, resets to all ones.
// - Seven-bit mode result sits in bits 6:0; upper bits invalid.
// - Self-clearing FIFO init bit 14 resets FIFOs and error flag.
// - Control register reports transmit empty bit 7, receive full bit 6.
// - Enable bits 2,1,0 gate receive, transmit and transfer interrupts.
// - Control bit 12 picks full duplex; refused while three-wire enabled.
module sscrc_top
  import sscrc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [SSCRC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [1:0] avs_byteenable_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic avs_response_out,
  input wire logic tx_empty_in,
  input wire logic rx_full_in,
  input wire logic fifo_error_event_in,
  input wire logic byte_rx_event_in,
  input wire logic byte_tx_event_in,
  input wire logic block_xfer_event_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic tx_bit_valid_in,
  input wire logic tx_bit_in,
  input wire logic rx_bit_valid_in,
  input wire logic rx_bit_in,
  output logic fifo_init_out,
  output logic full_duplex_out,
  output logic three_wire_out,
  output logic [7:0] tx_byte_out,
  output logic tx_byte_load_out,
  output logic byte_rx_irq_out,
  output logic byte_tx_irq_out,
  output logic block_xfer_irq_out
);
  // Register map and flag packing assume one 16-bit word per access
  if (DATA_W != 16) begin : g_width_check
    $error("sscrc_top serves 16-bit data only");
  end

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    logic response;
    logic done;
    logic fifo_error;
    logic byte_rx_irq;
    logic byte_tx_irq;
    logic block_xfer_irq;
    logic [2:0] irq_enable;
    logic full_duplex;
    logic three_wire;
    logic fifo_init;
    logic [1:0] crc_mode;
    logic crc_enable;
    logic crc_rx_sel;
    logic [15:0] crc;
    logic [7:0] tx_byte;
    logic tx_byte_load;
    logic irq_rx_out;
    logic irq_tx_out;
    logic irq_xfer_out;
  } sscrc_state_type;

  sscrc_state_type state;
  sscrc_state_type next_state;
  logic [15:0] crc_step;
  logic crc_bit;
  logic crc_bit_valid;

  function automatic logic [15:0] sscrc_mask(input logic [1:0] mode, input logic [15:0] value);
    sscrc_mask = (sscrc_mode_type'(mode) == SSCRC_MODE_CRC7) ? (value & SSCRC_CRC7_MASK) : value;
  endfunction

  // Half duplex has one active stream; receive bit taken while valid, else transmit
  always_comb begin
    if (state.full_duplex && state.crc_rx_sel) begin
      crc_bit = rx_bit_in;
      crc_bit_valid = rx_bit_valid_in;
    end else if (state.full_duplex) begin
      crc_bit = tx_bit_in;
      crc_bit_valid = tx_bit_valid_in;
    end else begin
      crc_bit = rx_bit_valid_in ? rx_bit_in : tx_bit_in;
      crc_bit_valid = rx_bit_valid_in | tx_bit_valid_in;
    end
  end

  sscrc_crc_engine u_crc (
    .mode_in(state.crc_mode),
    .crc_in(state.crc),
    .bit_in(crc_bit),
    .crc_out(crc_step)
  );

  always_comb begin
    logic [15:0] crc_flags;
    logic [15:0] eff_crc;
    logic wr;
    logic rd;
    logic [15:0] wd;
    next_state = state;
    crc_flags = 16'h0000;
    eff_crc = sscrc_mask(state.crc_mode, state.crc);
    wr = avs_write_in && !state.done;
    rd = avs_read_in && !state.done;
    wd = avs_writedata_in;
    next_state.fifo_init = 1'b0;
    next_state.tx_byte_load = 1'b0;
    next_state.readdata = 16'h0000;
    next_state.response = 1'b0;
    // Every access answers one cycle after it is seen, then gap cycle
    next_state.waitrequest = !(wr || rd);
    next_state.done = wr || rd;

    // serial update, MSB first through the engine
    if (state.crc_enable && crc_bit_valid) begin
      next_state.crc = crc_step;
    end

    crc_flags[SSCRC_CC_NOT_ZERO] = (eff_crc != 16'h0000);
    crc_flags[SSCRC_CC_NOT_ONES] = (eff_crc != sscrc_mask(state.crc_mode, SSCRC_CRC_RESET));

    if (wr) begin
      if (avs_address_in == SSCRC_IDX_CONTROL) begin
        if (wd[SSCRC_CT_FIFO_INIT]) begin
          next_state.fifo_init = 1'b1;
        end
        next_state.full_duplex = wd[SSCRC_CT_FULL_DUPLEX] && !state.three_wire;
      end else if (avs_address_in == SSCRC_IDX_CONFIG) begin
        next_state.three_wire = wd[SSCRC_CFG_THREE_WIRE];
        if (wd[SSCRC_CFG_THREE_WIRE]) begin
          next_state.full_duplex = 1'b0;
        end
      end else if (avs_address_in == SSCRC_IDX_IRQ_ENABLE) begin
        next_state.irq_enable = wd[2:0] & SSCRC_IEN_MASK;
      end else if (avs_address_in == SSCRC_IDX_IRQ_CLEAR) begin
        // Clear pulses last only this cycle; reserved bits ignored
        if (wd[SSCRC_CLR_TX]) begin
          next_state.byte_tx_irq = 1'b0;
        end
        if (wd[SSCRC_CLR_XFER]) begin
          next_state.block_xfer_irq = 1'b0;
        end
      end else if (avs_address_in == SSCRC_IDX_CRC_CONTROL) begin
        next_state.crc_mode = wd[SSCRC_CC_MODE_HI:SSCRC_CC_MODE_LO];
        next_state.crc_enable = wd[SSCRC_CC_ENABLE];
        next_state.crc_rx_sel = wd[SSCRC_CC_RX_SEL];
        if (wd[SSCRC_CC_PRESET]) begin
          next_state.crc = SSCRC_CRC_RESET;
        end
      end else if (avs_address_in == SSCRC_IDX_CRC_VALUE) begin
        next_state.crc = wd;
      end else if (avs_address_in == SSCRC_IDX_DATA_PORT) begin
        next_state.tx_byte = wd[7:0];
        next_state.tx_byte_load = 1'b1;
      end else if (avs_address_in == SSCRC_IDX_STATUS) begin
        next_state.response = 1'b0;
      end else begin
        next_state.response = 1'b1;
      end
    end

    if (rd) begin
      if (avs_address_in == SSCRC_IDX_STATUS) begin
        next_state.readdata[SSCRC_ST_FIFO_ERR] = state.fifo_error;
        next_state.readdata[SSCRC_ST_RX_IRQ] = state.byte_rx_irq;
        next_state.readdata[SSCRC_ST_TX_IRQ] = state.byte_tx_irq;
        next_state.readdata[SSCRC_ST_XFER_IRQ] = state.block_xfer_irq;
      end else if (avs_address_in == SSCRC_IDX_CONTROL) begin
        next_state.readdata[SSCRC_CT_FULL_DUPLEX] = state.full_duplex;
        next_state.readdata[SSCRC_CT_TX_EMPTY] = tx_empty_in;
        next_state.readdata[SSCRC_CT_RX_FULL] = rx_full_in;
      end else if (avs_address_in == SSCRC_IDX_CONFIG) begin
        next_state.readdata[SSCRC_CFG_THREE_WIRE] = state.three_wire;
      end else if (avs_address_in == SSCRC_IDX_IRQ_ENABLE) begin
        next_state.readdata[2:0] = state.irq_enable;
      end else if (avs_address_in == SSCRC_IDX_CRC_CONTROL) begin
        next_state.readdata = crc_flags;
        next_state.readdata[SSCRC_CC_MODE_HI:SSCRC_CC_MODE_LO] = state.crc_mode;
        next_state.readdata[SSCRC_CC_ENABLE] = state.crc_enable;
        next_state.readdata[SSCRC_CC_RX_SEL] = state.crc_rx_sel;
      end else if (avs_address_in == SSCRC_IDX_CRC_VALUE) begin
        next_state.readdata = state.crc;
      end else if (avs_address_in == SSCRC_IDX_DATA_PORT) begin
        next_state.readdata[7:0] = rx_byte_in;
        next_state.byte_rx_irq = 1'b0;
      end else if (avs_address_in == SSCRC_IDX_IRQ_CLEAR) begin
        next_state.readdata = 16'h0000;
      end else begin
        next_state.response = 1'b1;
      end
    end

    // FIFO init clears the error; a new error in the same cycle still wins
    if (next_state.fifo_init) begin
      next_state.fifo_error = 1'b0;
    end
    if (fifo_error_event_in) begin
      next_state.fifo_error = 1'b1;
    end
    // Events are recorded only when enabled; set beats clear
    if (byte_rx_event_in && state.irq_enable[SSCRC_ST_RX_IRQ]) begin
      next_state.byte_rx_irq = 1'b1;
    end
    if (byte_tx_event_in && state.irq_enable[SSCRC_ST_TX_IRQ]) begin
      next_state.byte_tx_irq = 1'b1;
    end
    if (block_xfer_event_in && state.irq_enable[SSCRC_ST_XFER_IRQ]) begin
      next_state.block_xfer_irq = 1'b1;
    end
    next_state.irq_rx_out = next_state.byte_rx_irq;
    next_state.irq_tx_out = next_state.byte_tx_irq;
    next_state.irq_xfer_out = next_state.block_xfer_irq;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= '0;
      state.waitrequest <= 1'b1;
      state.crc <= SSCRC_CRC_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata_out = state.readdata;
  assign avs_waitrequest_out = state.waitrequest;
  assign avs_response_out = state.response;
  assign fifo_init_out = state.fifo_init;
  assign full_duplex_out = state.full_duplex;
  assign three_wire_out = state.three_wire;
  assign tx_byte_out = state.tx_byte;
  assign tx_byte_load_out = state.tx_byte_load;
  assign byte_rx_irq_out = state.irq_rx_out;
  assign byte_tx_irq_out = state.irq_tx_out;
  assign block_xfer_irq_out = state.irq_xfer_out;
endmodule // sscrc_top

/* sscrc_sva.sv */
// Port-level checks of the SPI status, clear and CRC register block
module sscrc_sva
  import sscrc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [SSCRC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [DATA_W-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic avs_response_out,
  input wire logic byte_rx_event_in,
  input wire logic byte_tx_event_in,
  input wire logic block_xfer_event_in,
  input wire logic fifo_init_out,
  input wire logic byte_rx_irq_out,
  input wire logic byte_tx_irq_out,
  input wire logic block_xfer_irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence wr_done(a);
    avs_write_in && !avs_waitrequest_out && avs_address_in == a;
  endsequence
  sequence rd_done(a);
    avs_read_in && !avs_waitrequest_out && avs_address_in == a;
  endsequence
  a_wait_single: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_answer_bound: assert property ((avs_read_in || avs_write_in) |-> ##[0:2] !avs_waitrequest_out)
    else $error("request not answered in time");
  a_tx_clear: assert property (
    (wr_done(SSCRC_IDX_IRQ_CLEAR) ##0 (avs_writedata_in[1] && !byte_tx_event_in)) |-> ##[0:1] !byte_tx_irq_out)
    else $error("transmit flag not cleared");
  a_xfer_clear: assert property (
    (wr_done(SSCRC_IDX_IRQ_CLEAR) ##0 (avs_writedata_in[0] && !block_xfer_event_in)) |-> ##[0:1] !block_xfer_irq_out)
    else $error("transfer flag not cleared");
  a_rx_read_clear: assert property (
    (rd_done(SSCRC_IDX_DATA_PORT) ##0 !byte_rx_event_in) |-> ##[0:1] !byte_rx_irq_out)
    else $error("receive flag not cleared by data read");
  a_init_pulse: assert property (
    (wr_done(SSCRC_IDX_CONTROL) ##0 avs_writedata_in[14]) |-> ##[0:1] fifo_init_out ##1 !fifo_init_out)
    else $error("fifo init pulse wrong");
  a_preset_zero: assert property (rd_done(SSCRC_IDX_CRC_CONTROL) |-> !avs_readdata_out[12])
    else $error("preset bit read back as one");
  a_tx_cause: assert property ($rose(byte_tx_irq_out) |-> $past(byte_tx_event_in) || $past(byte_tx_event_in, 2))
    else $error("transmit flag rose without event");
  a_xfer_cause: assert property ($rose(block_xfer_irq_out) |-> $past(block_xfer_event_in) || $past(block_xfer_event_in, 2))
    else $error("transfer flag rose without event");
  a_unmapped_err: assert property (((avs_read_in || avs_write_in) && !avs_waitrequest_out
    && !(avs_address_in inside {[16'hC0C8:16'hC0D6]} && !avs_address_in[0])) |-> avs_response_out)
    else $error("unmapped access without error response");
endmodule // sscrc_sva
bind sscrc_top sscrc_sva #(.DATA_W(DATA_W)) u_sva (.*);

/* sscrc_partner.sv */
// Far-side serial source: shifts one 16-bit word, optionally with idle gaps
module sscrc_partner (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [15:0] word_in,
  input wire logic slow_in,
  output logic valid_out,
  output logic bit_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh = 16'h0000;
  logic [4:0] left = 5'h00;
  logic gap = 1'h0;
  initial valid_out = 1'h0;
  initial bit_out = 1'h0;
  // Plain process: the outputs also carry start-up values from initial blocks
  always @(posedge clk_in) begin
    if (start_in) begin
      sh <= word_in;
      left <= 5'h10;
      gap <= 1'h0;
      valid_out <= 1'h0;
    end else if (left != 5'h00 && !gap) begin
      valid_out <= 1'h1;
      bit_out <= sh[15];
      sh <= {sh[14:0], 1'h0};
      left <= left - 5'h01;
      gap <= slow_in;
    end else begin
      // Idle line toggles so a stale bit is never mistaken for data
      valid_out <= 1'h0;
      bit_out <= ~bit_out;
      gap <= 1'h0;
    end
  end
  assign busy_out = (left != 5'h00);
endmodule // sscrc_partner

/* sscrc_top_test.sv */
// Self-checking bench for the SPI status, clear and CRC block
module sscrc_top_test;
  import sscrc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, reset_n_in, avs_read_in, avs_write_in, tx_empty_in, rx_full_in, fifo_error_event_in;
  logic byte_rx_event_in, byte_tx_event_in, block_xfer_event_in, tx_bit_valid_in, tx_bit_in;
  logic rx_bit_valid_in, rx_bit_in, avs_waitrequest_out, avs_response_out, fifo_init_out, full_duplex_out;
  logic three_wire_out, tx_byte_load_out, byte_rx_irq_out, byte_tx_irq_out, block_xfer_irq_out, rsp;
  logic rx_go, tx_go, rx_busy, tx_busy;
  logic [1:0] avs_byteenable_in;
  logic [7:0] rx_byte_in, tx_byte_out;
  logic [15:0] avs_address_in, avs_writedata_in, avs_readdata_out, rdv, rx_w, tx_w;
  int fail_count = 0;
  int compares = 0;
  sscrc_top dut (.*);
  sscrc_partner rx_side (.clk_in(clk_in), .start_in(rx_go), .word_in(rx_w), .slow_in(1'h0),
    .valid_out(rx_bit_valid_in), .bit_out(rx_bit_in), .busy_out(rx_busy));
  sscrc_partner tx_side (.clk_in(clk_in), .start_in(tx_go), .word_in(tx_w), .slow_in(1'h1),
    .valid_out(tx_bit_valid_in), .bit_out(tx_bit_in), .busy_out(tx_busy));
  initial begin
    clk_in = 1'h0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic end_of_test;
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'h0 && n < 64);
    rdv = avs_readdata_out;
    rsp = avs_response_out;
    if (n >= 64) chk(16'h0001, 16'h0000);
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge clk_in);
    {fifo_error_event_in, byte_rx_event_in, byte_tx_event_in, block_xfer_event_in} <= m;
    @(posedge clk_in);
    {fifo_error_event_in, byte_rx_event_in, byte_tx_event_in, block_xfer_event_in} <= 4'h0;
  endtask
  task automatic shift(input logic r, input logic t, input logic [15:0] rw, input logic [15:0] tw);
    int n;
    n = 0;
    @(posedge clk_in);
    rx_w <= rw;
    tx_w <= tw;
    rx_go <= r;
    tx_go <= t;
    @(posedge clk_in);
    rx_go <= 1'h0;
    tx_go <= 1'h0;
    do begin
      @(posedge clk_in);
      n++;
    end while ((rx_busy || tx_busy) && n < 100);
    repeat (2) @(posedge clk_in);
  endtask
  // Own bit-serial reference: non-reflected, left shift, no final inversion
  function automatic logic [15:0] crc_ref(input logic [1:0] m, input logic [15:0] c, input logic [15:0] w);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = ((m == 2'h1) ? c[6] : c[15]) ^ w[i];
      if (m == 2'h1) c[6:0] = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
      else c = {c[14:0], 1'h0} ^ (fb ? ((m == 2'h2) ? 16'h8005 : 16'h1021) : 16'h0000);
    end
    return c;
  endfunction
  task automatic t_regs;
    acc(0, SSCRC_IDX_CRC_VALUE, 0); chk(rdv, 16'hFFFF);
    acc(0, SSCRC_IDX_CRC_CONTROL, 0); chk(rdv, 16'h0400);
    acc(1, SSCRC_IDX_STATUS, 16'hFFFF); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0000);
    acc(0, 16'hC0DA, 0); chk({rdv[14:0], rsp}, 16'h0001);
  endtask
  task automatic t_irq;
    ev(4'h7); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0000);
    acc(1, SSCRC_IDX_IRQ_ENABLE, 16'h0007);
    ev(4'h7); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0007);
    acc(1, SSCRC_IDX_IRQ_CLEAR, 0); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0007);
    acc(1, SSCRC_IDX_IRQ_CLEAR, 2); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0005);
    acc(1, SSCRC_IDX_IRQ_CLEAR, 1); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0004);
    acc(0, SSCRC_IDX_DATA_PORT, 0); chk({8'h00, rdv[7:0]}, 16'h00A5);
    acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0000);
    ev(4'h2); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0002);
    acc(1, SSCRC_IDX_IRQ_CLEAR, 2);
  endtask
  task automatic t_fifo;
    tx_empty_in <= 1'h1;
    ev(4'h8); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0080);
    acc(0, SSCRC_IDX_CONTROL, 0); chk(rdv & 16'h00C0, 16'h0080);
    rx_full_in <= 1'h1;
    tx_empty_in <= 1'h0;
    acc(0, SSCRC_IDX_CONTROL, 0); chk(rdv & 16'h00C0, 16'h0040);
    acc(0, SSCRC_IDX_STATUS, 0);
    chk(rdv, 16'h0080);
    acc(1, SSCRC_IDX_CONTROL, 16'h4000); acc(0, SSCRC_IDX_STATUS, 0); chk(rdv, 16'h0000);
    rx_full_in <= 1'h0;
  endtask
  task automatic t_data;
    acc(1, SSCRC_IDX_DATA_PORT, 16'h005A);
    chk({7'h00, tx_byte_load_out, tx_byte_out}, 16'h015A);
    @(posedge clk_in);
    chk({7'h00, tx_byte_load_out, tx_byte_out}, 16'h005A);
  endtask
  task automatic t_crc;
    logic [15:0] e;
    logic z, o;
    for (int m = 0; m < 4; m++) begin
      acc(1, SSCRC_IDX_CRC_CONTROL, {m[1:0], 14'h3000});
      shift(0, 1, 16'h0000, 16'h9E3B);
      e = crc_ref(m[1:0], 16'hFFFF, 16'h9E3B);
      z = (m == 1) ? (e[6:0] != 7'h00) : (e != 16'h0000);
      o = (m == 1) ? (e[6:0] != 7'h7F) : (e != 16'hFFFF);
      acc(0, SSCRC_IDX_CRC_VALUE, 0);
      chk((m == 1) ? {9'h000, rdv[6:0]} : rdv, (m == 1) ? {9'h000, e[6:0]} : e);
      acc(0, SSCRC_IDX_CRC_CONTROL, 0); chk(rdv, {m[1:0], 3'h4, z, o, 9'h000});
    end
    acc(1, SSCRC_IDX_CRC_CONTROL, 16'h1000);
    shift(0, 1, 16'h0000, 16'h9E3B);
    acc(0, SSCRC_IDX_CRC_VALUE, 0); chk(rdv, 16'hFFFF);
    acc(1, SSCRC_IDX_CRC_VALUE, 0); acc(0, SSCRC_IDX_CRC_CONTROL, 0); chk(rdv, 16'h0200);
  endtask
  task automatic t_duplex;
    acc(1, SSCRC_IDX_CONFIG, 0);
    acc(1, SSCRC_IDX_CONTROL, 16'h1000);
    chk({15'h0000, full_duplex_out}, 16'h0001);
    for (int s = 0; s < 2; s++) begin
      acc(1, SSCRC_IDX_CRC_CONTROL, {4'h3, s[0], 11'h000});
      shift(1, 1, 16'h1234, 16'hBEEF);
      acc(0, SSCRC_IDX_CRC_VALUE, 0); chk(rdv, crc_ref(2'h0, 16'hFFFF, s ? 16'h1234 : 16'hBEEF));
    end
    acc(1, SSCRC_IDX_CONFIG, 1);
    chk({14'h0000, three_wire_out, full_duplex_out}, 16'h0002);
    acc(1, SSCRC_IDX_CONTROL, 16'h1000);
    acc(0, SSCRC_IDX_CONTROL, 0); chk({15'h0000, rdv[12]}, 16'h0000);
  endtask
  initial begin
    {avs_read_in, avs_write_in, tx_empty_in, rx_full_in, rx_go, tx_go} = 6'h00;
    {fifo_error_event_in, byte_rx_event_in, byte_tx_event_in, block_xfer_event_in} = 4'h0;
    reset_n_in = 1'h0;
    avs_address_in = 16'h0000;
    avs_writedata_in = 16'h0000;
    avs_byteenable_in = 2'h3;
    rx_byte_in = 8'hA5;
    rx_w = 16'h0000;
    tx_w = 16'h0000;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'h1;
    t_regs;
    t_irq;
    t_data;
    t_fifo;
    t_crc;
    t_duplex;
    end_of_test;
  end
  initial begin
    // Whole sequence needs a few hundred cycles; this bound only catches a hang
    repeat (20000) @(posedge clk_in);
    fail_count++;
    end_of_test;
  end
endmodule // sscrc_top_test
